// [bus_agent_model.sv]
// far-side bus agent that starts transactions toward the block
// assumes the bench merges its drive with the block's, the block winning
`timescale 1ns/1ps
module bus_agent_model #(parameter [34:0] CFG = 35'h0) (
    output logic [34:0] addr,
    output logic [1:0]  par,
    output logic [1:0]  stb,
    output logic        ads
);
    initial begin
        addr = CFG;
        par = 2'h0;
        stb = 2'h0;
        ads = 1'b0;
    end
    // d is half the strobe high time in ns; data leads each strobe edge by d
    task automatic send(input logic [34:0] a, input logic [34:0] t, input logic bad,
                        input int d);
        ads = 1'b1;
        addr = a;
        par = {^a[34:17], ^a[16:0] ^ bad};
        #d;
        stb = 2'h3;
        #d;
        addr = t;
        par = {^t[34:17], ^t[16:0]};
        #d;
        stb = 2'h0;
        ads = 1'b0;
        #d;
        addr = ~t; // released lines keep no stale value
        par = ~par;
    endtask
endmodule

// [fsb_addr_defines.vh]
// constants for the address-phase block of the front-side bus
// assumes inclusion by bare name from the design files
`ifndef FSB_ADDR_DEFINES_VH
`define FSB_ADDR_DEFINES_VH
`define ADDR_MSB        37
`define ADDR_LSB        3
`define ADDR_W          35
`define MASK_BIT        20
`define MASK_IDX        17
`define PAR_W           2
`define PAR_SPLIT       17
`define CFG_W           35
`define ST_IDLE         2'h0
`define ST_SUB1         2'h1
`define ST_SUB2         2'h2
`endif

// [fsb_addr_phase.v]
// address-phase logic of the processor side of a shared front-side bus
// assumes pins are active high here (polarity inversion at the pads), core_clk
// much faster than the strobes, and that strobe edges are spaced by several cycles
`timescale 1ns/1ps
`include "fsb_addr_defines.vh"
module fsb_addr_phase #(
    parameter AW = `ADDR_W
) (
    input  wire          core_clk,
    input  wire          reset,
    // internal request side
    input  wire          req_valid,
    output wire          req_ready,
    input  wire [AW-1:0] req_addr,
    input  wire [AW-1:0] req_type,
    // bus pins, three signals each except the input-only mask pin; enable low while driving
    input  wire [AW-1:0] addr_in,
    output reg  [AW-1:0] addr_out,
    output reg           addr_oe_n,
    input  wire [1:0]    address_parity_pair_in,
    output reg  [1:0]    address_parity_pair_out,
    output reg           address_parity_pair_oe_n,
    input  wire [1:0]    address_source_strobes_in,
    output reg  [1:0]    address_source_strobes_out,
    output reg           address_source_strobes_oe_n,
    input  wire          transaction_valid_strobe_in,
    output reg           transaction_valid_strobe_out,
    output reg           transaction_valid_strobe_oe_n,
    input  wire          bit_twenty_mask_input,
    // internal cache lookup path
    input  wire [AW-1:0] lookup_addr,
    output reg  [AW-1:0] lookup_addr_masked,
    // received transaction, power-on configuration and mask state
    output reg           rx_valid,
    output reg  [AW-1:0] rx_addr,
    output reg  [AW-1:0] rx_type,
    output reg           rx_parity_error,
    output reg  [AW-1:0] power_on_config,
    output reg           mask_active
);
    localparam P_LO = `PAR_SPLIT;

    // every bus pin passes two flops first
    wire [AW-1:0] addr_s;
    wire [1:0]    par_s;
    wire [1:0]    stb_s;
    wire          ads_s;
    wire          mask_s;
    sync_two #(.WIDTH(AW + 6)) u_sync (
        .core_clk (core_clk),
        .din      ({addr_in, address_parity_pair_in, address_source_strobes_in,
                    transaction_valid_strobe_in, bit_twenty_mask_input}),
        .dout     ({addr_s, par_s, stb_s, ads_s, mask_s})
    );

    function [1:0] parity_of;
        input [AW-1:0] v;
        begin
            parity_of = {^v[AW-1:P_LO], ^v[P_LO-1:0]};
        end
    endfunction

    // mask applies only to bit 20
    function [AW-1:0] apply_mask;
        input [AW-1:0] v;
        input          m;
        begin
            apply_mask = v;
            if (m) begin
                apply_mask[`MASK_IDX] = 1'b0;
            end
        end
    endfunction

    // transmit side
    reg [1:0]    state;
    reg [1:0]    next_state;
    reg [AW-1:0] type_hold;
    assign req_ready = (state == `ST_IDLE) && !ads_s;

    always @* begin
        next_state = state;
        case (state)
            `ST_IDLE: if (req_valid && req_ready) next_state = `ST_SUB1;
            `ST_SUB1: next_state = `ST_SUB2;
            `ST_SUB2: next_state = `ST_IDLE;
            default:  next_state = `ST_IDLE;
        endcase
    end

    always @(posedge core_clk) begin
        if (reset) begin
            state                         <= `ST_IDLE;
            type_hold                     <= {AW{1'b0}};
            addr_out                      <= {AW{1'b0}};
            addr_oe_n                     <= 1'b1;
            address_parity_pair_out       <= 2'h0;
            address_parity_pair_oe_n      <= 1'b1;
            address_source_strobes_out    <= 2'h0;
            address_source_strobes_oe_n   <= 1'b1;
            transaction_valid_strobe_out  <= 1'b0;
            transaction_valid_strobe_oe_n <= 1'b1;
        end else begin
            state <= next_state;
            case (state)
                `ST_IDLE: begin
                    addr_oe_n                     <= 1'b1;
                    address_parity_pair_oe_n      <= 1'b1;
                    address_source_strobes_oe_n   <= 1'b1;
                    transaction_valid_strobe_oe_n <= 1'b1;
                    transaction_valid_strobe_out  <= 1'b0;
                    address_source_strobes_out    <= 2'h0;
                    if (req_valid && req_ready) begin
                        type_hold <= req_type;
                        addr_out  <= apply_mask(req_addr, mask_active);
                        address_parity_pair_out <=
                            parity_of(apply_mask(req_addr, mask_active));
                        addr_oe_n                     <= 1'b0;
                        address_parity_pair_oe_n      <= 1'b0;
                        address_source_strobes_oe_n   <= 1'b0;
                        transaction_valid_strobe_oe_n <= 1'b0;
                        transaction_valid_strobe_out  <= 1'b1;
                        address_source_strobes_out    <= 2'h3; // rising edge
                    end
                end
                `ST_SUB1: begin
                    addr_out                     <= type_hold;
                    address_parity_pair_out      <= parity_of(type_hold);
                    transaction_valid_strobe_out <= 1'b0;
                    address_source_strobes_out   <= 2'h0; // falling edge
                end
                default: begin
                    addr_oe_n                     <= 1'b1;
                    address_parity_pair_oe_n      <= 1'b1;
                    address_source_strobes_oe_n   <= 1'b1;
                    transaction_valid_strobe_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // receive side: strobe edges seen on the synchronised copy
    reg  [1:0] stb_d;
    reg        ads_d;
    reg        rx_armed;
    reg  [1:0] busy_hist;
    wire       stb_rise = (stb_s[0] & ~stb_d[0]) | (stb_s[1] & ~stb_d[1]);
    wire       stb_fall = (~stb_s[0] & stb_d[0]) | (~stb_s[1] & stb_d[1]);
    wire       ads_rise = ads_s & ~ads_d;
    // own pins come back through the sync flops late; ignore them that long too
    wire       own_drive = (state != `ST_IDLE) || (|busy_hist);

    always @(posedge core_clk) begin
        if (reset) begin
            stb_d           <= 2'h0;
            ads_d           <= 1'b0;
            rx_armed        <= 1'b0;
            busy_hist       <= 2'h0;
            rx_valid        <= 1'b0;
            rx_addr         <= {AW{1'b0}};
            rx_type         <= {AW{1'b0}};
            rx_parity_error <= 1'b0;
        end else begin
            stb_d     <= stb_s;
            ads_d     <= ads_s;
            busy_hist <= {busy_hist[0], state != `ST_IDLE};
            rx_valid  <= 1'b0;
            if (ads_rise && !own_drive) begin
                rx_armed <= 1'b1;
            end
            if (rx_armed && stb_rise) begin
                rx_addr         <= addr_s;
                rx_parity_error <= (parity_of(addr_s) != par_s);
            end
            if (rx_armed && stb_fall) begin
                rx_type  <= addr_s;
                rx_valid <= 1'b1;
                rx_armed <= 1'b0;
                if (parity_of(addr_s) != par_s) begin
                    rx_parity_error <= 1'b1;
                end
            end
        end
    end

    // power-on configuration caught on the first edge after reset release
    reg reset_d;
    always @(posedge core_clk) begin
        reset_d <= reset;
        if (reset) begin
            power_on_config <= {AW{1'b0}};
        end else if (reset_d) begin
            power_on_config <= addr_s;
        end
    end

    // mask state and cache lookup path
    always @(posedge core_clk) begin
        if (reset) begin
            mask_active        <= 1'b0;
            lookup_addr_masked <= {AW{1'b0}};
        end else begin
            // system keeps this low outside real mode; not checked here
            mask_active        <= mask_s;
            lookup_addr_masked <= apply_mask(lookup_addr, mask_s);
        end
    end
endmodule

// [fsb_addr_phase_properties.sv]
// checker for the address-phase block, watching its top-level ports only
// assumes a single core_clk domain and pins active high inside the block
`timescale 1ns/1ps
module fsb_addr_phase_properties #(parameter AW = 35) (
    input wire          core_clk,
    input wire          reset,
    input wire          req_valid,
    input wire          req_ready,
    input wire [AW-1:0] req_addr,
    input wire [AW-1:0] req_type,
    input wire [AW-1:0] addr_in,
    input wire [AW-1:0] addr_out,
    input wire          addr_oe_n,
    input wire [1:0]    address_parity_pair_out,
    input wire [1:0]    address_source_strobes_out,
    input wire          transaction_valid_strobe_out,
    input wire [AW-1:0] lookup_addr,
    input wire [AW-1:0] lookup_addr_masked,
    input wire          rx_valid,
    input wire [AW-1:0] power_on_config,
    input wire          mask_active
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wire go = req_valid & req_ready;
    // mask conditions need two steady cycles: the sync lag may differ by one
    property p_sub1; go |=> !addr_oe_n && transaction_valid_strobe_out
        && address_source_strobes_out == 2'h3; endproperty
    a_sub1: assert property (p_sub1) else $error("sub-phase 1 drive wrong");
    property p_sub2; go |=> ##1 !addr_oe_n && !transaction_valid_strobe_out
        && address_source_strobes_out == 2'h0 && addr_out == $past(req_type, 2); endproperty
    a_sub2: assert property (p_sub2) else $error("sub-phase 2 drive wrong");
    property p_rel; go |-> ##3 addr_oe_n; endproperty
    a_rel: assert property (p_rel) else $error("lines not released");
    property p_par; !addr_oe_n && transaction_valid_strobe_out |->
        address_parity_pair_out == {^addr_out[34:17], ^addr_out[16:0]}; endproperty
    a_par: assert property (p_par) else $error("parity wrong");
    property p_mask; go && mask_active && $past(mask_active) |=> !addr_out[17]; endproperty
    a_mask: assert property (p_mask) else $error("bit 20 driven while masked");
    property p_nomask; go && !mask_active && !$past(mask_active) |=>
        addr_out == $past(req_addr); endproperty
    a_nomask: assert property (p_nomask) else $error("address altered");
    property p_lkm; !$past(reset) && mask_active && $past(mask_active) |->
        !lookup_addr_masked[17]; endproperty
    a_lkm: assert property (p_lkm) else $error("lookup not masked");
    property p_lko; !$past(reset) |-> (lookup_addr_masked | 35'h2_0000) ==
        ($past(lookup_addr) | 35'h2_0000); endproperty
    a_lko: assert property (p_lko) else $error("lookup other bits wrong");
    property p_cfg; $fell(reset) |=> power_on_config == $past(addr_in)
        ##1 $stable(power_on_config) [*8]; endproperty
    a_cfg: assert property (p_cfg) else $error("config capture wrong");
    property p_rx; rx_valid |=> !rx_valid; endproperty
    a_rx: assert property (p_rx) else $error("rx_valid too long");
endmodule
bind fsb_addr_phase fsb_addr_phase_properties #(.AW(AW)) u_props (.core_clk, .reset,
    .req_valid, .req_ready, .req_addr, .req_type, .addr_in, .addr_out, .addr_oe_n,
    .address_parity_pair_out, .address_source_strobes_out, .transaction_valid_strobe_out,
    .lookup_addr, .lookup_addr_masked, .rx_valid, .power_on_config, .mask_active);

// [sync_two.v]
// two-flop synchroniser for a vector of levels from outside the core_clk domain
// assumes each bit is an independent level; no coherence across bits is promised
`timescale 1ns/1ps
module sync_two #(
    parameter WIDTH = 1
) (
    input  wire             core_clk,
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] stable;
    // no reset: pin levels must already be through both flops when reset lets go,
    // or the power-on sample would see unknown values
    always @(posedge core_clk) begin
        meta   <= din;
        stable <= meta;
    end
    assign dout = stable;
endmodule

// [tb_fsb_addr_phase.sv]
// self-checking bench for the address-phase block with one far-side agent
// assumes 25 MHz core_clk and inputs changed at the falling edge
`timescale 1ns/1ps
module tb_fsb_addr_phase;
    localparam [34:0] CFG = 35'h5_1234_5678;
    logic        core_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, mask = 1'b0, rx_err;
    logic [34:0] req_addr = 35'h0, req_type = 35'h0, lookup_addr = 35'h0;
    wire  [34:0] addr_out, lookup_addr_masked, rx_addr, rx_type, power_on_config, m_addr;
    wire  [1:0]  par_o, stb_o, m_par, m_stb;
    wire         req_ready, addr_oe_n, par_oe_n, stb_oe_n, ads_o, ads_oe_n, m_ads;
    wire         rx_valid, rx_parity_error, mask_active;
    int          fail_count = 0, checks = 0, rx_seen = 0;
    // each pin resolves to the block while it drives, else to the agent
    wire [34:0] addr_in = addr_oe_n === 1'b0 ? addr_out : m_addr;
    wire [1:0]  par_in = par_oe_n === 1'b0 ? par_o : m_par;
    wire [1:0]  stb_in = stb_oe_n === 1'b0 ? stb_o : m_stb;
    wire        ads_in = ads_oe_n === 1'b0 ? ads_o : m_ads;
    fsb_addr_phase u_dut (.core_clk, .reset, .req_valid, .req_ready, .req_addr, .req_type,
        .addr_in, .addr_out, .addr_oe_n, .address_parity_pair_in(par_in),
        .address_parity_pair_out(par_o), .address_parity_pair_oe_n(par_oe_n),
        .address_source_strobes_in(stb_in), .address_source_strobes_out(stb_o),
        .address_source_strobes_oe_n(stb_oe_n), .transaction_valid_strobe_in(ads_in),
        .transaction_valid_strobe_out(ads_o), .transaction_valid_strobe_oe_n(ads_oe_n),
        .bit_twenty_mask_input(mask), .lookup_addr, .lookup_addr_masked, .rx_valid,
        .rx_addr, .rx_type, .rx_parity_error, .power_on_config, .mask_active);
    bus_agent_model #(.CFG(CFG)) u_agent (.addr(m_addr), .par(m_par), .stb(m_stb),
        .ads(m_ads));
    initial forever #20 core_clk = ~core_clk;
    always @(posedge core_clk) if (rx_valid === 1'b1) begin
        rx_seen <= rx_seen + 1;
        rx_err <= rx_parity_error;
    end
    task automatic chk(input string what, input logic [34:0] exp, input logic [34:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done;
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic t_tx(input logic [34:0] a, input logic [34:0] t);
        req_addr = a;
        req_type = t;
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(negedge core_clk);
        @(negedge core_clk);
        req_valid = 1'b0;
        chk("addr sub1", mask ? a & ~35'h2_0000 : a, addr_out);
        chk("ads", 1'b1, ads_o);
        chk("drive", 1'b0, addr_oe_n);
        chk("pin drive", 3'h0, {par_oe_n, stb_oe_n, ads_oe_n});
        @(negedge core_clk);
        chk("addr sub2", t, addr_out);
        chk("strobes", 2'h0, stb_o);
        @(negedge core_clk);
        chk("release", 4'hf, {addr_oe_n, par_oe_n, stb_oe_n, ads_oe_n});
    endtask
    task automatic t_lookup(input logic on);
        mask = on; // the bench stands for a system held in real mode
        lookup_addr = 35'h7_FFFF_FFFF;
        repeat (4) @(negedge core_clk);
        chk("mask sync", on, mask_active);
        chk("lookup", on ? 35'h7_FFFD_FFFF : lookup_addr, lookup_addr_masked);
    endtask
    task automatic t_rx(input logic [34:0] a, input logic [34:0] t, input logic bad,
                        input int d);
        int n;
        n = rx_seen;
        u_agent.send(a, t, bad, d);
        repeat (4) @(negedge core_clk);
        chk("rx count", n + 1, rx_seen);
        chk("rx addr", a, rx_addr);
        chk("rx type", t, rx_type);
        chk("rx parity", bad, rx_err);
    endtask
    initial begin
        #100000;
        fail_count++;
        test_done;
    end
    initial begin
        repeat (12) @(negedge core_clk);
        reset = 1'b0;
        repeat (3) @(negedge core_clk);
        chk("config", CFG, power_on_config);
        t_tx(35'h1_2346_0008, 35'h0_0000_0005);
        t_lookup(1'b1);
        t_tx(35'h1_2346_0008, 35'h0_0000_0005);
        t_tx(35'h7_FFFF_FFFF, 35'h7_FFFF_FFFF);
        t_lookup(1'b0);
        t_rx(35'h5_5555_5555, 35'h2_AAAA_AAAA, 1'b0, 160);
        t_rx(35'h0_0002_0000, 35'h0_0000_0003, 1'b1, 160);
        test_done;
    end
endmodule
